// File: design/memdec_pkg.sv
package memdec_pkg;
    // Program space
    localparam int          PC_W        = 13;
    localparam int          IMPL_AW     = 11;
    localparam logic [12:0] RESET_VEC   = 13'h0000;
    localparam logic [12:0] IRQ_VEC     = 13'h0004;
    // Data space
    localparam int          DADDR_W     = 9;
    localparam int          BANK_LOC_W  = 7;
    localparam logic [6:0]  SFR_TOP     = 7'h1F;
    // Core register offsets within a bank
    localparam logic [6:0]  OFF_INDIRECT = 7'h00;
    localparam logic [6:0]  OFF_PCL      = 7'h02;
    localparam logic [6:0]  OFF_STATUS   = 7'h03;
    localparam logic [6:0]  OFF_POINTER  = 7'h04;
    localparam logic [6:0]  OFF_PROGRAM_COUNTER_HIGH_LATCH   = 7'h0A;
    localparam logic [6:0]  OFF_INTCTL   = 7'h0B;
    // General storage ranges
    localparam logic [8:0]  G0_LO  = 9'h020;
    localparam logic [8:0]  G0_HI  = 9'h07F;
    localparam logic [8:0]  G1_LO  = 9'h0A0;
    localparam logic [8:0]  G1_HI  = 9'h0BF;
    localparam logic [6:0]  SHARE_LO = 7'h70;
    localparam int          RAM_WORDS = 128;
    // Status field positions
    localparam int          ST_BANK_LOW  = 5;
    localparam int          ST_BANK_HIGH = 6;
    localparam int          ST_IND_BANK  = 7;
    localparam logic [7:0]  STATUS_RST  = 8'h18;
    localparam logic [7:0]  PROGRAM_COUNTER_HIGH_LATCH_RST  = 8'h00;
    localparam logic [7:0]  INTCTL_RST  = 8'h00;
    localparam logic [7:0]  POINTER_RST = 8'h00;

    // Data access request from the core
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       indirect;
        logic [6:0] opnd;
        logic [7:0] wdata;
    } data_req_type;

    // Program counter control from the core
    typedef struct packed {
        logic              inc;
        logic              irq;
        logic              jump;
        logic [PC_W-1:0]   target;
    } pc_ctl_type;
endpackage

// File: design/banked_memory_address_decode.sv
`timescale 1ns/10ps
module banked_memory_address_decode
    import memdec_pkg::*;
#(
    parameter int GEN_WORDS = 128
)(
    input  wire logic                       core_clk,  // Core clock
    input  wire logic                       rst_n,     // Synchronous reset, low
    input  wire memdec_pkg::pc_ctl_type     pc_ctl,    // Counter control
    input  wire memdec_pkg::data_req_type   dreq,      // Data access
    output logic [memdec_pkg::PC_W-1:0]     pc,        // Program counter
    output logic [memdec_pkg::IMPL_AW-1:0]  fetch_addr,// Physical fetch word
    output logic [7:0]                      rdata,     // Read data, next cycle
    output logic [8:0]                      daddr,     // Resolved data address
    output logic [7:0]                      status     // Status register
);
    import memdec_pkg::*;

    // Elaboration check: the scratch array and its remap serve exactly this depth
    if (GEN_WORDS != RAM_WORDS)
    begin
        $error("GEN_WORDS must equal the 128 scratch bytes served");
    end

    logic [PC_W-1:0]    pc_r;
    logic [PC_W-1:0]    pc_nxt;
    logic [7:0]         status_r;
    logic [7:0]         pointer_r;
    logic [7:0]         program_counter_high_latch_r;
    logic [7:0]         intctl_r;
    logic [7:0]         rdata_r;
    logic [8:0]         daddr_r;
    logic [IMPL_AW-1:0] fetch_r;
    logic [7:0]         ram_r [0:RAM_WORDS-1];

    // Address formation: pointer path ignores bank select bits
    wire logic [8:0] direct_addr = {status_r[ST_BANK_HIGH], status_r[ST_BANK_LOW],
                                    dreq.opnd};
    wire logic [8:0] ind_addr    = {status_r[ST_IND_BANK], pointer_r};
    wire logic [8:0] eff_addr    = dreq.indirect ? ind_addr : direct_addr;
    wire logic [1:0] bank        = eff_addr[8:7];
    wire logic [6:0] loc         = eff_addr[6:0];

    // Shared region decode, reused by read and write paths
    function automatic logic is_shared(input logic [6:0] l);
        return l >= SHARE_LO;
    endfunction

    wire logic in_sfr  = (loc <= SFR_TOP);
    wire logic in_g0   = (eff_addr >= G0_LO) && (eff_addr <= G0_HI);
    wire logic in_g1   = (eff_addr >= G1_LO) && (eff_addr <= G1_HI);
    wire logic in_alias = (bank != 2'b00) && is_shared(loc);
    wire logic gen_hit = in_g0 || in_g1 || in_alias;
    // Bank 1 storage lives in the unused low quarter of the array (00h-1Fh never
    // conflicts with bank 0 because bank 0 owns 20h-7Fh); remap to a free index.
    wire logic [6:0] ram_idx = in_alias ? loc :
                               in_g1    ? {2'b00, loc[4:0]} : loc;

    // Core registers decode identically in every bank
    wire logic hit_ind    = in_sfr && (loc == OFF_INDIRECT);
    wire logic hit_pcl    = in_sfr && (loc == OFF_PCL);
    wire logic hit_status = in_sfr && (loc == OFF_STATUS);
    wire logic hit_ptr    = in_sfr && (loc == OFF_POINTER);
    wire logic hit_program_counter_high_latch = in_sfr && (loc == OFF_PROGRAM_COUNTER_HIGH_LATCH);
    wire logic hit_intctl = in_sfr && (loc == OFF_INTCTL);
    wire logic core_hit   = hit_pcl || hit_status || hit_ptr || hit_program_counter_high_latch || hit_intctl;

    // Indirect port read through itself has no storage, reads zero
    wire logic [7:0] rd_mux =
        hit_pcl    ? pc_r[7:0] :
        hit_status ? status_r :
        hit_ptr    ? pointer_r :
        hit_program_counter_high_latch ? program_counter_high_latch_r :
        hit_intctl ? intctl_r :
        (gen_hit && !in_sfr) ? ram_r[ram_idx] : 8'h00;

    // A counter-low write outranks a jump so software computed jumps are lost only to an interrupt
    wire logic wr_pcl = dreq.wr && hit_pcl && !hit_ind;

    // Program counter next value; writes to the low byte jump via the latch
    always_comb
    begin
        pc_nxt = pc_r;
        if (pc_ctl.irq)
            pc_nxt = IRQ_VEC;
        else if (wr_pcl)
            pc_nxt = {program_counter_high_latch_r[PC_W-9:0], dreq.wdata};
        else if (pc_ctl.jump)
            pc_nxt = pc_ctl.target;
        else if (pc_ctl.inc)
            pc_nxt = PC_W'(pc_r + 1'b1);
    end

    // Counter and physical fetch address
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pc_r    <= RESET_VEC;
            fetch_r <= RESET_VEC[IMPL_AW-1:0];
        end
        else
        begin
            pc_r    <= pc_nxt;
            fetch_r <= pc_nxt[IMPL_AW-1:0];
        end
    end

    // Core registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            status_r  <= STATUS_RST;
            pointer_r <= POINTER_RST;
            program_counter_high_latch_r  <= PROGRAM_COUNTER_HIGH_LATCH_RST;
            intctl_r  <= INTCTL_RST;
        end
        else if (dreq.wr)
        begin
            if (hit_status) status_r  <= dreq.wdata;
            if (hit_ptr)    pointer_r <= dreq.wdata;
            if (hit_program_counter_high_latch) program_counter_high_latch_r  <= {3'b000, dreq.wdata[4:0]};
            if (hit_intctl) intctl_r  <= dreq.wdata;
        end
    end

    // Scratch storage; writes to unbacked locations are dropped
    always_ff @(posedge core_clk)
    begin
        if (dreq.wr && gen_hit && !in_sfr)
            ram_r[ram_idx] <= dreq.wdata;
    end

    // Registered read data and address
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rdata_r <= 8'h00;
            daddr_r <= 9'h000;
        end
        else
        begin
            rdata_r <= dreq.rd ? rd_mux : 8'h00;
            daddr_r <= eff_addr;
        end
    end

    assign pc         = pc_r;
    assign fetch_addr = fetch_r;
    assign rdata      = rdata_r;
    assign daddr      = daddr_r;
    assign status     = status_r;

    // Checks
    property p_reset_vec;
        @(posedge core_clk) !rst_n |=> (pc == RESET_VEC);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("pc not 0 after reset");

    property p_irq_vec;
        @(posedge core_clk) disable iff (!rst_n) pc_ctl.irq |=> (pc == IRQ_VEC);
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("pc not 4 after irq");

    property p_wrap;
        @(posedge core_clk) disable iff (!rst_n) fetch_addr == pc[IMPL_AW-1:0];
    endproperty
    a_wrap: assert property (p_wrap) else $error("fetch not wrapped pc");

    property p_inc;
        @(posedge core_clk) disable iff (!rst_n)
            (pc_ctl.inc && !pc_ctl.irq && !pc_ctl.jump && !wr_pcl)
            |=> pc == PC_W'($past(pc) + 1'b1);
    endproperty
    a_inc: assert property (p_inc) else $error("pc did not increment");

    property p_direct;
        @(posedge core_clk) disable iff (!rst_n) !dreq.indirect
            |=> daddr == {$past(status[6]), $past(status[5]), $past(dreq.opnd)};
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");

    property p_indirect;
        @(posedge core_clk) disable iff (!rst_n) dreq.indirect
            |=> daddr == {$past(status[7]), $past(pointer_r)};
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect address wrong");

    property p_unbacked;
        @(posedge core_clk) disable iff (!rst_n)
            (dreq.rd && !in_sfr && !gen_hit) |=> rdata == 8'h00;
    endproperty
    a_unbacked: assert property (p_unbacked) else $error("unbacked read not zero");

    property p_status_all_banks;
        @(posedge core_clk) disable iff (!rst_n)
            (dreq.rd && !dreq.indirect && dreq.opnd == OFF_STATUS) |=> rdata == $past(status);
    endproperty
    a_status_all_banks: assert property (p_status_all_banks)
        else $error("status decode");

    // A jump takes the target unless an interrupt or counter-low write outranks it
    property p_jump;
        @(posedge core_clk) disable iff (!rst_n)
            (pc_ctl.jump && !pc_ctl.irq && !wr_pcl) |=> pc == $past(pc_ctl.target);
    endproperty
    a_jump: assert property (p_jump) else $error("pc did not take jump target");

    // With no command the counter must not drift
    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
            !(pc_ctl.inc || pc_ctl.irq || pc_ctl.jump || wr_pcl) |=> $stable(pc);
    endproperty
    a_hold: assert property (p_hold) else $error("pc moved without a command");

    // A write to the counter low byte is one step: latch bits join the data byte
    sequence s_pcl_write;
        dreq.wr && hit_pcl && !pc_ctl.irq;
    endsequence

    property p_pcl_write;
        @(posedge core_clk) disable iff (!rst_n)
            s_pcl_write |=> pc == {$past(program_counter_high_latch_r[PC_W-9:0]), $past(dreq.wdata)};
    endproperty
    a_pcl_write: assert property (p_pcl_write) else $error("pc low write lost");

    // Storage round trip: a stored byte reads back after an idle cycle
    sequence s_store;
        dreq.wr && gen_hit && !in_sfr;
    endsequence

    sequence s_load_same;
        dreq.rd && !dreq.wr && gen_hit && !in_sfr && (ram_idx == $past(ram_idx, 2));
    endsequence

    property p_store_load;
        @(posedge core_clk) disable iff (!rst_n)
            s_store ##1 !dreq.wr ##1 s_load_same |=> rdata == $past(dreq.wdata, 3);
    endproperty
    a_store_load: assert property (p_store_load) else $error("stored byte lost");

    // Unimplemented special registers and the indirect port itself have no storage
    property p_sfr_zero;
        @(posedge core_clk) disable iff (!rst_n)
            (dreq.rd && in_sfr && !core_hit) |=> rdata == 8'h00;
    endproperty
    a_sfr_zero: assert property (p_sfr_zero) else $error("empty special slot not zero");

    property p_pointer_all_banks;
        @(posedge core_clk) disable iff (!rst_n)
            (dreq.rd && !dreq.indirect && dreq.opnd == OFF_POINTER)
            |=> rdata == $past(pointer_r);
    endproperty
    a_pointer_all_banks: assert property (p_pointer_all_banks)
        else $error("pointer decode");

    property p_latch_all_banks;
        @(posedge core_clk) disable iff (!rst_n)
            (dreq.rd && !dreq.indirect && dreq.opnd == OFF_PROGRAM_COUNTER_HIGH_LATCH)
            |=> rdata == $past(program_counter_high_latch_r);
    endproperty
    a_latch_all_banks: assert property (p_latch_all_banks)
        else $error("latch decode");

    // Interrupt entry lands inside the backed program space
    property p_irq_fetch;
        @(posedge core_clk) disable iff (!rst_n)
            pc_ctl.irq |=> fetch_addr == IRQ_VEC[IMPL_AW-1:0];
    endproperty
    a_irq_fetch: assert property (p_irq_fetch) else $error("irq fetch word wrong");

    // Bank field of a direct access follows the two select bits, upper bit first
    property p_bank_select;
        @(posedge core_clk) disable iff (!rst_n)
            !dreq.indirect |=> daddr[8:7] == $past(status[ST_BANK_HIGH:ST_BANK_LOW]);
    endproperty
    a_bank_select: assert property (p_bank_select) else $error("bank field wrong");

    // Fetch word also restarts at the reset vector
    property p_reset_fetch;
        @(posedge core_clk) !rst_n |=> (fetch_addr == RESET_VEC[IMPL_AW-1:0]);
    endproperty
    a_reset_fetch: assert property (p_reset_fetch) else $error("fetch reset wrong");

    // Shared window of any upper bank must land on the bank 0 top sixteen bytes
    property p_alias_index;
        @(posedge core_clk) disable iff (!rst_n)
            (in_alias && (dreq.rd || dreq.wr)) |-> (ram_idx == {3'h7, loc[3:0]});
    endproperty
    a_alias_index: assert property (p_alias_index) else $error("alias index wrong");
endmodule

// File: bench/core_model.sv
`timescale 1ns/10ps
// Core stand-in: issues one data request or counter command per call
module core_model
    import memdec_pkg::*;
(
    input  wire logic                core_clk, // Core clock
    output memdec_pkg::pc_ctl_type   pc_ctl,   // Counter control
    output memdec_pkg::data_req_type dreq      // Data access
);
    // Idle at time zero so nothing is requested during reset
    initial
    begin
        pc_ctl = '0;
        dreq   = '0;
    end
    // Held one cycle; on release the operand lines flip so stale values never look valid
    task automatic acc(input logic rd, input logic wr, input logic ind,
                       input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk);
        dreq <= '{rd: rd, wr: wr, indirect: ind, opnd: a, wdata: d};
        @(posedge core_clk);
        dreq <= '{rd: 1'b0, wr: 1'b0, indirect: ~ind, opnd: ~a, wdata: ~d};
        #1;
    endtask
    // Counter command for one cycle
    task automatic pcop(input logic inc, input logic irq, input logic jmp, input logic [12:0] t);
        @(posedge core_clk);
        pc_ctl <= '{inc: inc, irq: irq, jump: jmp, target: t};
        @(posedge core_clk);
        pc_ctl <= '0;
        #1;
    endtask
endmodule

// File: bench/tb_banked_memory_address_decode.sv
`timescale 1ns/10ps
module tb_banked_memory_address_decode;
    import memdec_pkg::*;
    logic         core_clk = 1'b0;
    logic         rst_n = 1'b0;
    pc_ctl_type   pc_ctl;
    data_req_type dreq;
    logic [12:0]  pc, t;
    logic [10:0]  fetch_addr;
    logic [7:0]   rdata, status, v, p;
    logic [8:0]   daddr, a;
    logic [7:0]   mem [0:511];
    bit   [511:0] known;
    int           fails = 0, num_checks = 0, cyc = 0, seed = 58775, k;

    initial forever #2.5 core_clk = ~core_clk;
    core_model i_core (.core_clk(core_clk), .pc_ctl(pc_ctl), .dreq(dreq));
    banked_memory_address_decode i_dut (.core_clk(core_clk), .rst_n(rst_n), .pc_ctl(pc_ctl),
        .dreq(dreq), .pc(pc), .fetch_addr(fetch_addr), .rdata(rdata), .daddr(daddr),
        .status(status));

    // Backed slot of a data address, 1FFh where nothing is stored; shared window folds to bank 0
    function automatic logic [8:0] slot(input logic [8:0] ad);
        if (ad[6:0] >= 7'h70) return {2'b00, ad[6:0]};
        if (ad[8:7] == 2'b00 && ad[6:0] >= 7'h20) return ad;
        if (ad[8:7] == 2'b01 && ad[6:0] >= 7'h20 && ad[6:0] <= 7'h3F) return ad;
        return 9'h1FF;
    endfunction

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk("pc", pc, 16'h0000);
        chk("status", status, {8'h00, STATUS_RST});
        chk("rdata", rdata, 16'h0000);
        // Jumps, including the top word, then an increment that wraps
        for (k = 0; k < 8; k++)
        begin
            t = (k == 0) ? 13'h1FFF : 13'($random(seed));
            i_core.pcop(1'b0, 1'b0, 1'b1, t);
            chk("pc", pc, t);
            chk("fetch", fetch_addr, t[10:0]);
            i_core.pcop(1'b1, 1'b0, 1'b0, 13'h0000);
            t = t + 13'h0001;
            chk("pc_inc", pc, t);
            chk("fetch_inc", fetch_addr, t[10:0]);
        end
        i_core.pcop(1'b1, 1'b1, 1'b1, 13'h0123);
        chk("pc_irq", pc, 16'h0004);
        $display("test counter done");
        // Direct accesses: shared window first, then unbacked corners, then random
        for (k = 0; k < 80; k++)
        begin
            a = 9'($random(seed));
            v = 8'($random(seed));
            if (a[6:0] < 7'h20)
                a[5] = 1'b1;
            if (k < 4)
                a = {k[1:0], 7'h7F};
            if (k == 4)
                a = 9'h0C0;
            if (k == 5)
                a = 9'h120;
            i_core.acc(1'b0, 1'b1, 1'b0, OFF_STATUS, {1'b0, a[8:7], 5'h18});
            chk("bank", status[7:5], {1'b0, a[8:7]});
            if ((k == 0) || (k > 5 && v[0]))
            begin
                i_core.acc(1'b0, 1'b1, 1'b0, a[6:0], v);
                if (slot(a) != 9'h1FF)
                begin
                    mem[slot(a)] = v;
                    known[slot(a)] = 1'b1;
                end
            end
            else
            begin
                i_core.acc(1'b1, 1'b0, 1'b0, a[6:0], v);
                if (slot(a) == 9'h1FF)
                    chk("rdata_none", rdata, 16'h0000);
                else if (known[slot(a)])
                    chk("rdata", rdata, mem[slot(a)]);
            end
            chk("daddr", daddr, a);
        end
        $display("test direct done");
        // Indirect: pointer plus top status bit, bank bits scrambled
        for (k = 0; k < 10; k++)
        begin
            p = (k == 0) ? 8'h00 : 8'($random(seed)) | 8'h20;
            v = 8'($random(seed));
            a = {v[7], p};
            i_core.acc(1'b0, 1'b1, 1'b0, OFF_POINTER, p);
            i_core.acc(1'b0, 1'b1, 1'b0, OFF_STATUS, {v[7:5], 5'h18});
            if (k > 0)
                i_core.acc(1'b0, 1'b1, 1'b1, v[6:0], ~v);
            if (k > 0 && slot(a) != 9'h1FF)
                mem[slot(a)] = ~v;
            i_core.acc(1'b1, 1'b0, 1'b1, ~v[6:0], 8'h00);
            chk("daddr_ind", daddr, a);
            chk("rdata_ind", rdata, (slot(a) == 9'h1FF) ? 8'h00 : mem[slot(a)]);
        end
        $display("test indirect done");
        // Core registers at one offset in every bank, then a counter-low write
        i_core.acc(1'b0, 1'b1, 1'b0, OFF_PROGRAM_COUNTER_HIGH_LATCH, 8'h15);
        i_core.acc(1'b0, 1'b1, 1'b0, OFF_INTCTL, 8'h3C);
        for (k = 0; k < 4; k++)
        begin
            i_core.acc(1'b0, 1'b1, 1'b0, OFF_STATUS, {1'b0, k[1:0], 5'h18});
            i_core.acc(1'b1, 1'b0, 1'b0, OFF_STATUS, 8'h00);
            chk("status_rd", rdata, {1'b0, k[1:0], 5'h18});
            i_core.acc(1'b1, 1'b0, 1'b0, OFF_PROGRAM_COUNTER_HIGH_LATCH, 8'h00);
            chk("latch", rdata, 16'h0015);
            i_core.acc(1'b1, 1'b0, 1'b0, OFF_POINTER, 8'h00);
            chk("pointer", rdata, p);
            i_core.acc(1'b1, 1'b0, 1'b0, OFF_INTCTL, 8'h00);
            chk("intctl", rdata, 16'h003C);
            i_core.acc(1'b1, 1'b0, 1'b0, OFF_INDIRECT, 8'h00);
            chk("port_rd", rdata, 16'h0000);
            i_core.acc(1'b1, 1'b0, 1'b0, 7'h01, 8'h00);
            chk("sfr_empty", rdata, 16'h0000);
        end
        i_core.acc(1'b0, 1'b1, 1'b0, OFF_PCL, 8'hA7);
        chk("pc_load", pc, 16'h15A7);
        $display("test core registers done");
        print_verdict();
    end
endmodule
